/* hw/rivu_top.v */
/*
  reset and interrupt vector unit: vector placement, external interrupt 2,
  reset-cause flags and i/o register access. rstn_i is the power-on reset;
  other reset causes arrive as asynchronous levels.
*/
`timescale 1ns/10ps
`include "rivu_map.vh"
module rivu_top (
  input wire mclk_i,
  input wire rstn_i,
  input wire [6:0] io_addr_i,
  input wire io_mem_i,
  input wire io_wr_i,
  input wire io_rd_i,
  input wire [7:0] io_wdata_i,
  input wire io_bset_i,
  input wire io_bclr_i,
  input wire [2:0] io_bit_i,
  output wire [7:0] io_rdata_o,
  input wire cpu_gie_i,
  input wire boot_reset_fuse_i,
  input wire [13:0] boot_addr_i,
  input wire [19:0] irq_src_i,
  input wire irq_ack_i,
  output wire irq_req_o,
  output wire [4:0] irq_num_o,
  output wire [13:0] irq_vec_o,
  output wire [13:0] reset_addr_o,
  input wire ext_irq2_pin_i,
  input wire rst_pin_i,
  input wire rst_wdt_i,
  input wire rst_bor_i,
  input wire rst_testport_i
);
  // io or data-space address to io offset, msb flags a hit
  function [6:0] rivu_ioaddr;
    input [6:0] addr;
    input mem;
    reg [6:0] ofs;
    begin
      // subtract at full width, keep the six offset bits
      ofs = addr - `RIVU_MEM_OFS;
      if (mem) begin
        if (addr >= `RIVU_MEM_OFS && addr < `RIVU_MEM_END) begin
          rivu_ioaddr = {1'b1, ofs[5:0]};
        end else begin
          rivu_ioaddr = 7'h00;
        end
      end else begin
        rivu_ioaddr = {~addr[6], addr[5:0]};
      end
    end
  endfunction

  // lowest pending vector number, zero if none
  function [4:0] rivu_prio;
    input [19:0] pend;
    integer k;
    begin
      rivu_prio = 5'h00;
      for (k = `RIVU_NUM_VEC - 1; k >= 0; k = k - 1) begin
        if (pend[k]) begin
          rivu_prio = k[4:0] + 5'h01;
        end
      end
    end
  endfunction

  reg [7:0] cause_reg;
  reg [7:0] cause_next;
  reg ext_irq2_pin_en_reg;
  reg vsel_reg;
  reg ext_irq2_pin_flag_reg;
  reg ext_irq2_pin_flag_next;
  reg [7:0] rdata_reg;
  reg irq_req_reg;
  reg [4:0] irq_num_reg;
  reg [13:0] irq_vec_reg;
  reg [13:0] reset_addr_reg;
  reg [3:0] rst_s1_reg;
  reg [3:0] rst_s2_reg;
  reg [3:0] rst_s3_reg;
  reg [1:0] fuse_sync_reg;
  reg tog_s1_reg;
  reg tog_s2_reg;
  reg tog_s3_reg;
  reg [7:0] rd_val;
  reg [7:0] wr_val;
  wire [6:0] io_hit;
  wire [5:0] io_ofs;
  wire bit_op;
  wire wr_en;
  wire [7:0] bit_mask;
  wire [3:0] rst_event;
  wire ext_irq2_pin_event;
  wire edge_toggle;
  wire [19:0] pend;
  wire [4:0] num;
  wire [13:0] vec_base;

  rivu_edge_capture u_edge (
    .rstn_i(rstn_i),
    .ext_irq2_pin_i(ext_irq2_pin_i),
    .ext_irq2_edge_sel_i(cause_reg[`RIVU_CAUSE_EDGE]),
    .edge_toggle_o(edge_toggle)
  );

  assign io_hit = rivu_ioaddr(io_addr_i, io_mem_i);
  assign io_ofs = io_hit[5:0];
  // bit instructions reach only the low range by io address
  assign bit_op = (io_bset_i | io_bclr_i) & ~io_mem_i & ~io_addr_i[6] & (io_addr_i[5:0] < `RIVU_BIT_LIMIT);
  assign wr_en = (io_wr_i & io_hit[6]) | bit_op;
  assign bit_mask = 8'h01 << io_bit_i;

  // current value of the addressed register
  always @* begin
    rd_val = 8'h00;
    case (io_ofs)
      `RIVU_IO_CAUSE: begin
        rd_val = cause_reg & ~(8'h01 << `RIVU_CAUSE_RSVD);
      end
      `RIVU_IO_GIMSK: begin
        rd_val[`RIVU_MASK_EXT_IRQ2_PIN] = ext_irq2_pin_en_reg;
        rd_val[`RIVU_MASK_VSEL] = vsel_reg;
      end
      `RIVU_IO_GIFLG: begin
        rd_val[`RIVU_FLAG_EXT_IRQ2_PIN] = ext_irq2_pin_flag_reg;
      end
      default: begin
        rd_val = 8'h00;
      end
    endcase
  end

  // bit set or clear writes back the whole register
  always @* begin
    if (bit_op) begin
      wr_val = io_bset_i ? (rd_val | bit_mask) : (rd_val & ~bit_mask);
    end else begin
      wr_val = io_wdata_i;
    end
  end

  // reset causes and edge toggle through two flops, third for edge
  assign rst_event = rst_s2_reg & ~rst_s3_reg;
  assign ext_irq2_pin_event = tog_s2_reg ^ tog_s3_reg;

  always @* begin
    cause_next = cause_reg;
    if (wr_en && io_ofs == `RIVU_IO_CAUSE) begin
      cause_next[`RIVU_CAUSE_EDGE] = wr_val[`RIVU_CAUSE_EDGE];
      cause_next[4:0] = cause_reg[4:0] & wr_val[4:0];
    end
    cause_next[7] = 1'b0;
    cause_next[`RIVU_CAUSE_RSVD] = 1'b0;
    // set wins over a clear in the same cycle
    if (rst_event[3]) begin
      cause_next[`RIVU_CAUSE_TP] = 1'b1;
    end
    if (rst_event[2]) begin
      cause_next[`RIVU_CAUSE_WD] = 1'b1;
    end
    if (rst_event[1]) begin
      cause_next[`RIVU_CAUSE_BO] = 1'b1;
    end
    if (rst_event[0]) begin
      cause_next[`RIVU_CAUSE_PIN] = 1'b1;
    end
  end

  always @* begin
    ext_irq2_pin_flag_next = ext_irq2_pin_flag_reg;
    if (wr_en && io_ofs == `RIVU_IO_GIFLG && wr_val[`RIVU_FLAG_EXT_IRQ2_PIN]) begin
      ext_irq2_pin_flag_next = 1'b0;
    end
    if (irq_ack_i && irq_num_reg == `RIVU_VEC_EXT_IRQ2_PIN) begin
      ext_irq2_pin_flag_next = 1'b0;
    end
    if (ext_irq2_pin_event) begin
      ext_irq2_pin_flag_next = 1'b1;
    end
  end

  // vector 3 is interrupt 2, the rest come from peripherals
  assign pend = {irq_src_i[19:3], ext_irq2_pin_flag_reg & ext_irq2_pin_en_reg, irq_src_i[1:0]};
  assign num = rivu_prio(pend);
  assign vec_base = vsel_reg ? boot_addr_i : `RIVU_RESET_PC;

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cause_reg <= `RIVU_CAUSE_RST;
      ext_irq2_pin_en_reg <= 1'b0;
      vsel_reg <= 1'b0;
      ext_irq2_pin_flag_reg <= 1'b0;
      rdata_reg <= 8'h00;
      irq_req_reg <= 1'b0;
      irq_num_reg <= 5'h00;
      irq_vec_reg <= 14'h0000;
      reset_addr_reg <= 14'h0000;
      rst_s1_reg <= 4'h0;
      rst_s2_reg <= 4'h0;
      rst_s3_reg <= 4'h0;
      fuse_sync_reg <= 2'h0;
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
    end else begin
      rst_s1_reg <= {rst_testport_i, rst_wdt_i, rst_bor_i, rst_pin_i};
      rst_s2_reg <= rst_s1_reg;
      rst_s3_reg <= rst_s2_reg;
      fuse_sync_reg <= {fuse_sync_reg[0], boot_reset_fuse_i};
      tog_s1_reg <= edge_toggle;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
      cause_reg <= cause_next;
      ext_irq2_pin_flag_reg <= ext_irq2_pin_flag_next;
      if (wr_en && io_ofs == `RIVU_IO_GIMSK) begin
        ext_irq2_pin_en_reg <= wr_val[`RIVU_MASK_EXT_IRQ2_PIN];
        vsel_reg <= wr_val[`RIVU_MASK_VSEL];
      end
      if (io_rd_i) begin
        rdata_reg <= io_hit[6] ? rd_val : 8'h00;
      end
      irq_req_reg <= cpu_gie_i & (num != 5'h00);
      irq_num_reg <= num;
      irq_vec_reg <= vec_base + {8'h00, num, 1'b0};
      reset_addr_reg <= fuse_sync_reg[1] ? boot_addr_i : `RIVU_RESET_PC;
    end
  end

  assign io_rdata_o = rdata_reg;
  assign irq_req_o = irq_req_reg;
  assign irq_num_o = irq_num_reg;
  assign irq_vec_o = irq_vec_reg;
  assign reset_addr_o = reset_addr_reg;
endmodule // rivu_top

/* hw/rivu_map.vh */
/*
  constants for the reset and interrupt vector unit: i/o offsets, field positions,
  reset values and timing counts. assumes an 8-bit core i/o bus on a 20 MHz clock.
*/
`ifndef RIVU_MAP_VH
`define RIVU_MAP_VH

// i/o offsets
`define RIVU_IO_GIMSK 6'h1B
`define RIVU_IO_GIFLG 6'h1A
`define RIVU_IO_CAUSE 6'h14
`define RIVU_MEM_OFS 7'h20
`define RIVU_MEM_END 7'h60
`define RIVU_BIT_LIMIT 6'h20

// reset-cause fields
`define RIVU_CAUSE_EDGE 6
`define RIVU_CAUSE_RSVD 5
`define RIVU_CAUSE_TP 4
`define RIVU_CAUSE_WD 3
`define RIVU_CAUSE_BO 2
`define RIVU_CAUSE_PIN 1
`define RIVU_CAUSE_PO 0
`define RIVU_CAUSE_RST 8'h01

// mask and flag fields
`define RIVU_MASK_EXT_IRQ2_PIN 5
`define RIVU_MASK_VSEL 1
`define RIVU_FLAG_EXT_IRQ2_PIN 5

// vectors
`define RIVU_NUM_VEC 20
`define RIVU_VEC_EXT_IRQ2_PIN 5'h03
`define RIVU_PC_W 14
`define RIVU_RESET_PC 14'h0000

// timing
`define RIVU_CLK_NS 50
`define RIVU_EDGE_MIN_NS 50
`define RIVU_EDGE_MIN_CYC ((`RIVU_EDGE_MIN_NS + `RIVU_CLK_NS - 1) / `RIVU_CLK_NS)

`endif

/* hw/rivu_edge_capture.v */
/*
  clockless edge capture for external interrupt 2: a toggle flop clocked by the pin.
  assumes the system side synchronises the toggle output.
*/
`timescale 1ns/10ps
module rivu_edge_capture (
  input wire rstn_i,
  input wire ext_irq2_pin_i,
  input wire ext_irq2_edge_sel_i,
  output wire edge_toggle_o
);
  reg toggle_reg;
  wire trig;

  // falling edge when select low, rising when high
  assign trig = ext_irq2_edge_sel_i ? ext_irq2_pin_i : ~ext_irq2_pin_i;

  always @(posedge trig or negedge rstn_i) begin
    if (!rstn_i) begin
      toggle_reg <= 1'b0;
    end else begin
      toggle_reg <= ~toggle_reg;
    end
  end

  assign edge_toggle_o = toggle_reg;
endmodule // rivu_edge_capture

/* verif/rivu_core_model.sv */
/* core stand-in: acknowledges a pending request after a set lag
   assumes the unit's clock and power-on reset */
`timescale 1ns/10ps
module rivu_core_model (
  input wire mclk_i,
  input wire rstn_i,
  input wire irq_req_i,
  input wire [3:0] lag_i,
  output logic irq_ack_o
);
  logic [3:0] wait_reg;
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_ack_o <= 1'b0;
      wait_reg <= 4'h0;
    end else begin
      irq_ack_o <= 1'b0;
      if (!irq_req_i || irq_ack_o) wait_reg <= 4'h0;
      else if (wait_reg >= lag_i) irq_ack_o <= 1'b1;
      else wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule // rivu_core_model

/* verif/rivu_chk.sv */
/* port checker for rivu_top
   assumes one clock and rstn_i as power-on reset */
`timescale 1ns/10ps
module rivu_chk (
  input wire mclk_i,
  input wire rstn_i,
  input wire io_rd_i,
  input wire io_mem_i,
  input wire [6:0] io_addr_i,
  input wire [7:0] io_rdata_o,
  input wire cpu_gie_i,
  input wire boot_reset_fuse_i,
  input wire [13:0] boot_addr_i,
  input wire [19:0] irq_src_i,
  input wire irq_req_o,
  input wire [4:0] irq_num_o,
  input wire [13:0] irq_vec_o,
  input wire [13:0] reset_addr_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  wire [13:0] off = {8'h00, irq_num_o, 1'b0};
  a_no_req_gie: assert property (!cpu_gie_i |=> !irq_req_o) else $error("request without enable");
  a_vec_place: assert property (irq_req_o |-> irq_vec_o == off || irq_vec_o == boot_addr_i + off)
    else $error("vector address wrong");
  a_boot_start: assert property (boot_reset_fuse_i [*4] |-> reset_addr_o == boot_addr_i)
    else $error("boot reset address wrong");
  a_zero_start: assert property (!boot_reset_fuse_i [*4] |-> reset_addr_o == 14'h0000)
    else $error("reset address not zero");
  a_lowest_first: assert property (irq_src_i[0] && cpu_gie_i |=> irq_req_o && irq_num_o == 5'h01)
    else $error("lowest vector not first");
  a_req_follows: assert property (cpu_gie_i && |(irq_src_i & 20'hFFFFB) |=> irq_req_o)
    else $error("pending request not raised");
  a_rsvd_zero: assert property (io_rd_i && io_addr_i == (io_mem_i ? 7'h34 : 7'h14) |=> !io_rdata_o[5])
    else $error("reserved bit reads one");
  a_rdata_hold: assert property (!io_rd_i |=> $stable(io_rdata_o)) else $error("read data moved");
  c_ext_irq2_pin: cover property (irq_req_o && irq_num_o == 5'h03);
  c_moved: cover property (irq_req_o && irq_vec_o != off);
  c_cause_rd: cover property (io_rd_i && io_addr_i == 7'h14);
endmodule // rivu_chk
bind rivu_top rivu_chk u_rivu_chk (
  .mclk_i(mclk_i),
  .rstn_i(rstn_i),
  .io_rd_i(io_rd_i),
  .io_mem_i(io_mem_i),
  .io_addr_i(io_addr_i),
  .io_rdata_o(io_rdata_o),
  .cpu_gie_i(cpu_gie_i),
  .boot_reset_fuse_i(boot_reset_fuse_i),
  .boot_addr_i(boot_addr_i),
  .irq_src_i(irq_src_i),
  .irq_req_o(irq_req_o),
  .irq_num_o(irq_num_o),
  .irq_vec_o(irq_vec_o),
  .reset_addr_o(reset_addr_o)
);

/* verif/reset_irq_vector_unit_bench.sv */
/* self-checking bench for rivu_top with a core stand-in
   assumes header on the include path */
`timescale 1ns/10ps
module reset_irq_vector_unit_bench;
  logic mclk_i = 0, rstn_i = 0, io_mem_i = 0, io_wr_i = 0, io_rd_i = 0, io_bset_i = 0, io_bclr_i = 0;
  logic cpu_gie_i = 0, boot_reset_fuse_i = 0, irq_ack_i, ext_irq2_pin_i = 0, irq_req_o;
  logic [6:0] io_addr_i = 7'h00;
  logic [7:0] io_wdata_i = 8'h00, io_rdata_o, rnd = 8'h13, flags;
  logic [2:0] io_bit_i = 3'h0;
  logic [13:0] boot_addr_i = 14'h0000, irq_vec_o, reset_addr_o;
  logic [19:0] irq_src_i = 20'h00000;
  logic [4:0] irq_num_o, e;
  logic [3:0] cs = 4'h0, lag = 4'h0;
  int bad_count = 0, tests_run = 0;
  always #25 mclk_i = ~mclk_i;
  rivu_top u_rivu_top (.mclk_i(mclk_i), .rstn_i(rstn_i), .io_addr_i(io_addr_i), .io_mem_i(io_mem_i),
    .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_bset_i(io_bset_i),
    .io_bclr_i(io_bclr_i), .io_bit_i(io_bit_i), .io_rdata_o(io_rdata_o), .cpu_gie_i(cpu_gie_i),
    .boot_reset_fuse_i(boot_reset_fuse_i), .boot_addr_i(boot_addr_i), .irq_src_i(irq_src_i),
    .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o), .irq_num_o(irq_num_o), .irq_vec_o(irq_vec_o),
    .reset_addr_o(reset_addr_o), .ext_irq2_pin_i(ext_irq2_pin_i), .rst_pin_i(cs[0]), .rst_bor_i(cs[1]),
    .rst_wdt_i(cs[2]), .rst_testport_i(cs[3]));
  rivu_core_model u_rivu_core_model (.mclk_i(mclk_i), .rstn_i(rstn_i), .irq_req_i(irq_req_o), .lag_i(lag),
    .irq_ack_o(irq_ack_i));
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function [4:0] low_vec(input [19:0] s);
    low_vec = 5'h00;
    for (int k = 19; k >= 0; k--) if (s[k]) low_vec = 5'(k + 1);
  endfunction
  task chk(input [13:0] got, input [13:0] want);
    tests_run++;
    if (got !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task acc(input [6:0] a, input [7:0] d, input bit rd);
    @(negedge mclk_i);
    io_addr_i = a;
    io_mem_i = a >= 7'h20;
    io_wdata_i = d;
    io_wr_i = !rd;
    io_rd_i = rd;
    @(negedge mclk_i);
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
    if (rd) chk(io_rdata_o, d);
  endtask
  task bop(input bit set, input [6:0] a, input [2:0] b);
    @(negedge mclk_i);
    io_addr_i = a;
    io_mem_i = 1'b0;
    io_bit_i = b;
    io_bset_i = set;
    io_bclr_i = !set;
    @(negedge mclk_i);
    io_bset_i = 1'b0;
    io_bclr_i = 1'b0;
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    report_and_stop;
  end
  initial begin
    rnd = lfsr(rnd);
    boot_addr_i = {rnd, 6'h00};
    tick(5);
    chk(irq_req_o, 14'h0000);
    chk(io_rdata_o, 14'h0000);
    chk(reset_addr_o, 14'h0000);
    rstn_i = 1'b1;
    for (int r = 0; r < 2; r++) begin
      flags = 8'h01;
      acc(7'h14, flags, 1);
      for (int k = 0; k < 4; k++) begin
        cs[k] = 1'b1;
        tick(4);
        cs[k] = 1'b0;
        flags = flags | (8'h02 << k);
        acc(7'h14, flags, 1);
      end
      if (r == 0) begin
        rstn_i = 1'b0;
        tick(2);
        rstn_i = 1'b1;
      end
    end
    repeat (6) begin
      rnd = lfsr(rnd);
      acc(7'h14, rnd, 0);
      flags = (rnd & 8'h40) | (flags & rnd & 8'h1F);
      acc(7'h34, flags, 1);
    end
    $display("test reset_cause done");
    acc(7'h1B, 8'h22, 0);
    acc(7'h3B, 8'h22, 1);
    acc(7'h05, 8'h00, 1);
    bop(0, 7'h1B, 3'h5);
    acc(7'h1B, 8'h02, 1);
    bop(1, 7'h3B, 3'h5);
    acc(7'h1B, 8'h02, 1);
    bop(1, 7'h1B, 3'h5);
    acc(7'h1A, 8'h20, 0);
    $display("test registers done");
    cpu_gie_i = 1'b1;
    repeat (8) begin
      rnd = lfsr(rnd);
      irq_src_i = {rnd[3:0], rnd, rnd} & 20'hFFFFB;
      e = low_vec(irq_src_i);
      tick(1);
      chk(irq_num_o, e);
      chk(irq_vec_o, boot_addr_i + {e, 1'b0});
    end
    bop(0, 7'h1B, 3'h1);
    irq_src_i = 20'h00010;
    tick(1);
    chk(irq_vec_o, 14'h000A);
    cpu_gie_i = 1'b0;
    tick(1);
    chk(irq_req_o, 14'h0000);
    irq_src_i = 20'h00000;
    $display("test vectors done");
    for (int p = 1; p >= 0; p--) begin
      acc(7'h1B, 8'h00, 0);
      acc(7'h14, {1'b0, p[0], 6'h1F}, 0);
      acc(7'h1A, 8'h20, 0);
      acc(7'h1B, 8'h20, 0);
      #7 ext_irq2_pin_i = p[0];
      tick(6);
      acc(7'h1A, 8'h20, 1);
      bop(1, 7'h1A, 3'h0);
      acc(7'h1A, 8'h00, 1);
    end
    lag = 4'hF;
    #7 ext_irq2_pin_i = 1'b1;
    #60 ext_irq2_pin_i = 1'b0;
    tick(1);
    cpu_gie_i = 1'b1;
    tick(6);
    chk(irq_num_o, 14'h0003);
    chk(irq_vec_o, 14'h0006);
    tick(20);
    chk(irq_req_o, 14'h0000);
    $display("test ext_irq2 done");
    boot_reset_fuse_i = 1'b1;
    tick(4);
    chk(reset_addr_o, boot_addr_i);
    $display("test boot_fuse done");
    report_and_stop;
  end
endmodule // reset_irq_vector_unit_bench
